// file: common/gauge_status_pkg.sv
`default_nettype none
package gauge_status_pkg;
  // word and field widths
  localparam int WORD_W = 16;
  localparam int ACC_W = 15;
  localparam int POS_W = 12;
  localparam int VEL_W = 8;
  localparam int CNT_W = 5;
  localparam int CAL_CNT_W = 12;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  // command address field and codes
  localparam int CMD_ADDR_HI = 15;
  localparam int CMD_ADDR_LO = 13;
  localparam logic [2:0] CMD_CONFIG = 3'h1;
  localparam logic [2:0] CMD_ZERO_CONFIG = 3'h2;
  // config_and_status_select_cmd fields
  localparam int GAUGE_ENABLE_BIT = 0;
  localparam int CLOCK_CAL_ENABLE_BIT = 3;
  localparam int CLOCK_TARGET_SELECT_BIT = 4;
  localparam int SEL_HI = 11;
  localparam int SEL_LO = 8;
  localparam logic [3:0] SEL_RESET = 4'h0;
  // zero return configuration fields
  localparam int STEP_TIME_HI = 3;
  localparam int STEP_TIME_LO = 0;
  localparam int BLANKING_BIT = 4;
  localparam logic [3:0] STEP_TIME_RESET = 4'h0;
  // status word bit positions
  localparam int RUN_BIT = 15;
  localparam int GAUGE_ON_BIT = 15;
  localparam int DIR_BIT = 14;
  localparam int TARGET_DIR_BIT = 13;
  localparam int OFF_TARGET_BIT = 12;
  localparam int SIGN_BIT = 14;
  // timing
  localparam int MCLK_PERIOD_NS = 20;
  localparam int CAL_PULSE_NS = 8000;
  localparam int CAL_PULSE_CYCLES = (CAL_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // pin synchroniser: {reset pin, si, sclk, cs_n}; cs idles high
  localparam logic [3:0] SYNC_RESET = 4'h1;

  typedef enum logic [3:0] {
    KIND_DEVICE = 4'b0001,
    KIND_ACC = 4'b0010,
    KIND_POS = 4'b0100,
    KIND_VEL = 4'b1000
  } status_kind_type;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_ARMED = 3'b010,
    CAL_MEASURE = 3'b100
  } cal_state_type;

  // select bits 11:8 to status kind
  function automatic status_kind_type kind_of(input logic [3:0] sel);
    status_kind_type k;
    k = KIND_DEVICE;
    if (sel[3:2] == 2'b10) begin
      k = KIND_ACC;
    end else if (sel == 4'hC) begin
      k = KIND_POS;
    end else if (sel[3:1] == 3'h7) begin
      k = KIND_VEL;
    end
    return k;
  endfunction : kind_of
endpackage : gauge_status_pkg
`default_nettype wire

// file: common/status_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface status_link_if;
  logic load;
  logic [15:0] load_word;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic si_bit;
  logic so_bit;
  logic [15:0] rx_word;
  logic [4:0] rx_count;

  modport core (
    output load, load_word, sclk_rise, sclk_fall, cs_active, si_bit,
    input so_bit, rx_word, rx_count
  );
  modport shifter (
    input load, load_word, sclk_rise, sclk_fall, cs_active, si_bit,
    output so_bit, rx_word, rx_count
  );
endinterface : status_link_if
`default_nettype wire

// file: hw/status_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module status_shifter
  import gauge_status_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // link to the core
  status_link_if.shifter lnk
);
  logic [WORD_W-1:0] tx_r;
  logic [WORD_W-1:0] rx_r;
  logic [CNT_W-1:0] cnt_r;

  // transmit side: only the load ever writes new content
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_r <= '0;
    end else if (lnk.load) begin
      tx_r <= lnk.load_word; // R22
    end else if (lnk.sclk_fall && lnk.cs_active) begin
      tx_r <= {tx_r[WORD_W-2:0], 1'b0};
    end
  end

  // receive side; counter saturates so long frames stay invalid
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_r <= '0;
      cnt_r <= '0;
    end else if (lnk.load) begin
      cnt_r <= '0;
    end else if (lnk.sclk_rise && lnk.cs_active) begin
      rx_r <= {rx_r[WORD_W-2:0], lnk.si_bit};
      if (cnt_r != '1) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  assign lnk.so_bit = tx_r[WORD_W-1];
  assign lnk.rx_word = rx_r;
  assign lnk.rx_count = cnt_r;

  AST_SO_FIRST_BIT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
    lnk.load |=> lnk.so_bit == $past(lnk.load_word[WORD_W-1]))
    else $error("first output bit is not the loaded word msb");
  AST_SHIFT_IN_NO_EFFECT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R15
    (lnk.sclk_rise && !lnk.sclk_fall && !lnk.load) |=> $stable(tx_r))
    else $error("shifted-in data altered the status word");
endmodule : status_shifter
`default_nettype wire

// file: hw/gauge_status_readout.sv
//
// Contract
// R1 - accumulator word carries 15-bit integral value
// R2 - integral cleared by reset and pin rise
// R3 - integral held after run until next
// R4 - two's complement, bit 14 sign detects stop
// R5 - select 1100 gives position word
// R6 - select 111x gives velocity word
// R7 - position bit 15 shows gauge enabled
// R8 - position bit 14 shows away-from-zero
// R9 - position bit 13 shows away-from-target
// R10 - position bit 12 shows not at target
// R11 - position bits 11:0 sampled at CS fall
// R12 - velocity low byte is step index
// R13 - velocity upper byte carries no meaning
// R14 - step index counts untruncated ramp
// R15 - status bits never altered by input data
// R16 - host sets bit 0 to enable gauge
// R17 - host bit 3 starts calibration, bit 4 target
// R18 - one 8 us CS pulse calibrates clock
// R19 - host sets step time and blanking bit
// R20 - selected status kept until changed or reset
// R21 - select 10xx gives accumulator, bit 15 run
// R22 - word loaded at CS fall, shifted out
`timescale 1ns/1ps
`default_nettype none
module gauge_status_readout
  import gauge_status_pkg::*;
(
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // external reset pin, active low
  input wire logic rst_pin_n_i,
  // pointer state from the motion logic
  input wire logic gauge_moving_away_i,
  input wire logic direction_vs_target_flag_i,
  input wire logic off_target_i,
  input wire logic [11:0] pointer_location_i,
  input wire logic [7:0] ramp_step_raw_i,
  input wire logic [1:0] ramp_shortening_select_i,
  input wire logic [15:0] device_status_word_i,
  // return to zero run and back-emf samples
  input wire logic return_to_zero_active_i,
  input wire logic bemf_valid_i,
  input wire logic [14:0] bemf_sample_i,
  // configuration outputs
  output logic gauge_on_flag_o,
  output logic clock_cal_enable_o,
  output logic clock_target_select_o,
  output logic [3:0] zero_return_step_time_o,
  output logic zero_return_blanking_o,
  output logic [3:0] status_select_o,
  // calibration and zero detect results
  output logic [11:0] cal_count_o,
  output logic cal_done_o,
  output logic zero_stop_o
);
  // reset release and pin synchronisers
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [3:0] sync_a_r;
  logic [3:0] sync_b_r;
  logic [3:0] prev_r;
  logic cs_n_s;
  logic pin_s;
  logic cs_fall;
  logic cs_rise;
  logic pin_rise;
  logic dev_clr;
  // command and configuration state
  logic [3:0] sel_r;
  logic gauge_on_r;
  logic cal_en_r;
  logic target_sel_r;
  logic [3:0] step_time_r;
  logic blanking_r;
  logic frame_ok;
  logic [2:0] cmd_code;
  logic take_config;
  logic take_zero_config;
  // accumulator
  logic [ACC_W-1:0] zero_return_integral_r;
  logic run_prev_r;
  logic run_start;
  logic zero_stop_r;
  // calibration
  cal_state_type cal_state_r;
  cal_state_type cal_state_nxt;
  logic [CAL_CNT_W-1:0] cal_cnt_r;
  logic [CAL_CNT_W-1:0] cal_count_r;
  logic cal_done_r;
  // status words
  logic [7:0] ramp_step_index;
  logic [7:0] shorten_offset;
  logic [WORD_W-1:0] acc_word;
  logic [WORD_W-1:0] pos_word;
  logic [WORD_W-1:0] vel_word;
  logic [WORD_W-1:0] sel_word;
  status_kind_type kind;

  status_link_if lnk ();

  // hold the core in reset two edges past the release of rst_n_i
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // two sync flops and an edge flop per pin; the first stage is never looked at
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          sync_a_r[gi] <= SYNC_RESET[gi];
          sync_b_r[gi] <= SYNC_RESET[gi];
          prev_r[gi] <= SYNC_RESET[gi];
        end else begin
          sync_a_r[gi] <= (gi == 0) ? cs_n_i : (gi == 1) ? sclk_i :
                          (gi == 2) ? si_i : rst_pin_n_i;
          sync_b_r[gi] <= sync_a_r[gi];
          prev_r[gi] <= sync_b_r[gi];
        end
      end
    end
  endgenerate

  // edge pulses from the synchronised pins
  assign cs_n_s = sync_b_r[0];
  assign pin_s = sync_b_r[3];
  assign cs_fall = prev_r[0] && !cs_n_s;
  assign cs_rise = !prev_r[0] && cs_n_s;
  assign pin_rise = !prev_r[3] && pin_s;
  assign dev_clr = !pin_s;

  // drive the shifter; sclk edges only count while cs is low
  assign lnk.load = cs_fall;
  assign lnk.load_word = sel_word;
  assign lnk.sclk_rise = !prev_r[1] && sync_b_r[1];
  assign lnk.sclk_fall = prev_r[1] && !sync_b_r[1];
  assign lnk.cs_active = !cs_n_s;
  assign lnk.si_bit = sync_b_r[2];

  status_shifter u_shifter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .lnk(lnk)
  );

  // a frame counts only with exactly sixteen clocks inside cs
  assign frame_ok = cs_rise && (lnk.rx_count == FRAME_BITS);
  assign cmd_code = lnk.rx_word[CMD_ADDR_HI:CMD_ADDR_LO];
  assign take_config = frame_ok && (cmd_code == CMD_CONFIG);
  assign take_zero_config = frame_ok && (cmd_code == CMD_ZERO_CONFIG);

  // configuration and status select command
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= SEL_RESET;
      gauge_on_r <= 1'b0;
      cal_en_r <= 1'b0;
      target_sel_r <= 1'b0;
    end else if (dev_clr) begin
      sel_r <= SEL_RESET; // R20
      gauge_on_r <= 1'b0;
      cal_en_r <= 1'b0;
      target_sel_r <= 1'b0;
    end else if (take_config) begin
      sel_r <= lnk.rx_word[SEL_HI:SEL_LO]; // R20
      gauge_on_r <= lnk.rx_word[GAUGE_ENABLE_BIT]; // R16
      cal_en_r <= lnk.rx_word[CLOCK_CAL_ENABLE_BIT]; // R17
      target_sel_r <= lnk.rx_word[CLOCK_TARGET_SELECT_BIT]; // R17
    end
  end

  // zero return configuration command
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      step_time_r <= STEP_TIME_RESET;
      blanking_r <= 1'b0;
    end else if (dev_clr) begin
      step_time_r <= STEP_TIME_RESET;
      blanking_r <= 1'b0;
    end else if (take_zero_config) begin
      step_time_r <= lnk.rx_word[STEP_TIME_HI:STEP_TIME_LO]; // R19
      blanking_r <= lnk.rx_word[BLANKING_BIT]; // R19
    end
  end

  // integrate back-emf during a run; a new run starts from zero
  assign run_start = return_to_zero_active_i && !run_prev_r;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      zero_return_integral_r <= '0; // R2
      run_prev_r <= 1'b0;
    end else begin
      run_prev_r <= return_to_zero_active_i;
      if (dev_clr || pin_rise) begin
        zero_return_integral_r <= '0; // R2
      end else if (run_start) begin
        zero_return_integral_r <= '0;
      end else if (return_to_zero_active_i && bemf_valid_i) begin
        // wraps in two's complement like the converter's own adder
        zero_return_integral_r <= zero_return_integral_r + bemf_sample_i; // R4
      end
      // outside a run the last result stays put until the reset pin clears it
    end
  end

  // a negative integral during a run marks the zero stop
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      zero_stop_r <= 1'b0;
    end else begin
      zero_stop_r <= return_to_zero_active_i && zero_return_integral_r[SIGN_BIT]; // R4
    end
  end

  // calibration state: armed by the command, measures the next cs pulse
  always_comb begin
    cal_state_nxt = cal_state_r;
    unique case (cal_state_r)
      CAL_IDLE: begin
        if (take_config && lnk.rx_word[CLOCK_CAL_ENABLE_BIT]) begin
          cal_state_nxt = CAL_ARMED; // R18
        end
      end
      CAL_ARMED: begin
        if (cs_fall) begin
          cal_state_nxt = CAL_MEASURE;
        end
      end
      CAL_MEASURE: begin
        if (cs_rise) begin
          cal_state_nxt = CAL_IDLE;
        end
      end
      default: begin
        cal_state_nxt = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_r <= CAL_IDLE;
    end else if (dev_clr) begin
      cal_state_r <= CAL_IDLE;
    end else begin
      cal_state_r <= cal_state_nxt;
    end
  end

  // pulse width in mclk cycles; saturates so a stuck cs cannot wrap
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cal_cnt_r <= '0;
      cal_count_r <= CAL_CNT_W'(CAL_PULSE_CYCLES);
      cal_done_r <= 1'b0;
    end else begin
      cal_done_r <= 1'b0;
      if (cal_state_r == CAL_ARMED) begin
        cal_cnt_r <= '0;
      end else if (cal_state_r == CAL_MEASURE) begin
        if (cs_rise) begin
          cal_count_r <= cal_cnt_r; // R18
          cal_done_r <= 1'b1;
        end else if (cal_cnt_r != '1) begin
          cal_cnt_r <= cal_cnt_r + 12'h001;
        end
      end
    end
  end

  // a shortened ramp starts further in, so add the skipped steps back
  assign shorten_offset = (ramp_shortening_select_i == 2'h0) ? 8'h00 :
                          {6'h00, ramp_shortening_select_i} + 8'h01;
  assign ramp_step_index = ramp_step_raw_i + shorten_offset; // R14

  // the three words built here, sampled by the shifter at cs fall
  assign acc_word = {return_to_zero_active_i, zero_return_integral_r}; // R1
  assign pos_word = {gauge_on_r, gauge_moving_away_i, direction_vs_target_flag_i,
                     off_target_i, pointer_location_i}; // R7 R8 R9 R10 R11
  // upper byte carries no meaning, so it is held at zero rather than left floating
  assign vel_word = {8'h00, ramp_step_index}; // R12 R13

  // choose the word by the stored select bits
  assign kind = kind_of(sel_r);
  always_comb begin
    sel_word = device_status_word_i;
    unique case (kind)
      KIND_ACC: sel_word = acc_word; // R21
      KIND_POS: sel_word = pos_word; // R5
      KIND_VEL: sel_word = vel_word; // R6
      KIND_DEVICE: sel_word = device_status_word_i;
    endcase
  end

  // outputs
  assign so_o = lnk.so_bit; // R22
  assign so_oe_n_o = cs_n_s;
  assign gauge_on_flag_o = gauge_on_r;
  assign clock_cal_enable_o = cal_en_r;
  assign clock_target_select_o = target_sel_r;
  assign zero_return_step_time_o = step_time_r;
  assign zero_return_blanking_o = blanking_r;
  assign status_select_o = sel_r;
  assign cal_count_o = cal_count_r;
  assign cal_done_o = cal_done_r;
  assign zero_stop_o = zero_stop_r;

  AST_ACC_CLEARED: assert property (@(posedge mclk_i) disable iff (!rst_n) // R2
    pin_rise |=> zero_return_integral_r == '0)
    else $error("integral not cleared after reset pin rise");
  AST_ACC_HELD: assert property (@(posedge mclk_i) disable iff (!rst_n) // R3
    (!return_to_zero_active_i && pin_s && !pin_rise) |=> $stable(zero_return_integral_r))
    else $error("integral changed outside a run");
  AST_ACC_WORD: assert property (@(posedge mclk_i) disable iff (!rst_n) // R1
    (cs_fall && sel_r[3:2] == 2'b10) |-> lnk.load_word[14:0] == zero_return_integral_r
      && lnk.load_word[RUN_BIT] == return_to_zero_active_i)
    else $error("accumulator word wrong");
  AST_ZERO_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n) // R4
    (return_to_zero_active_i && zero_return_integral_r[SIGN_BIT]) |=> zero_stop_o)
    else $error("negative integral did not flag zero stop");
  AST_POS_WORD: assert property (@(posedge mclk_i) disable iff (!rst_n) // R5
    (cs_fall && sel_r == 4'hC) |-> lnk.load_word == {gauge_on_flag_o, gauge_moving_away_i,
      direction_vs_target_flag_i, off_target_i, pointer_location_i})
    else $error("position word wrong");
  AST_VEL_WORD: assert property (@(posedge mclk_i) disable iff (!rst_n) // R6
    (cs_fall && sel_r[3:1] == 3'h7) |-> lnk.load_word[15:8] == 8'h00
      && lnk.load_word[7:0] == ramp_step_raw_i + shorten_offset)
    else $error("velocity word wrong");
  AST_SEL_KEPT: assert property (@(posedge mclk_i) disable iff (!rst_n) // R20
    (!take_config && pin_s) |=> $stable(sel_r))
    else $error("status select changed without a command");
  AST_CAL_RESULT: assert property (@(posedge mclk_i) disable iff (!rst_n) // R18
    (cal_state_r == CAL_MEASURE && cs_rise) |=> cal_done_o && cal_count_o == $past(cal_cnt_r))
    else $error("calibration count not captured at pulse end");
endmodule : gauge_status_readout
`default_nettype wire

// file: dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // clock shared with the device
  input wire logic mclk_i,
  // serial pins toward the device
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i
);
  // four cycles a phase keeps above the three-cycle minimum with margin
  localparam int HALF = 4;

  // idle bus: deselected, clock low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_clk

  // one frame, msb first; si changes with the falling clock, so is taken while high
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    wait_clk(8);
    for (int i = 0; i < nbits; i++) begin
      si_o <= tx[15-i];
      wait_clk(HALF);
      sclk_o <= 1'b1;
      wait_clk(HALF);
      rx[15-i] = so_i;
      sclk_o <= 1'b0;
    end
    wait_clk(HALF);
    cs_n_o <= 1'b1;
    // a released data line flips so a stale bit never passes for data
    si_o <= ~si_o;
    wait_clk(10);
  endtask : xfer

  // single low pulse on select, no clock, used as the time reference
  task automatic cal_pulse(input int low_cycles);
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    wait_clk(low_cycles);
    cs_n_o <= 1'b1;
    wait_clk(10);
  endtask : cal_pulse
endmodule : spi_host_model
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gauge_status_pkg::*;
  logic mclk_i, rst_n_i, cs_n_i, sclk_i, si_i, so_o, so_oe_n_o, rst_pin_n_i;
  logic gauge_moving_away_i, direction_vs_target_flag_i, off_target_i;
  logic [11:0] pointer_location_i;
  logic [7:0] ramp_step_raw_i;
  logic [1:0] ramp_shortening_select_i;
  logic [15:0] device_status_word_i;
  logic return_to_zero_active_i, bemf_valid_i;
  logic [14:0] bemf_sample_i;
  logic gauge_on_flag_o, clock_cal_enable_o, clock_target_select_o, zero_return_blanking_o;
  logic [3:0] zero_return_step_time_o, status_select_o;
  logic [11:0] cal_count_o;
  logic cal_done_o, zero_stop_o;
  int mismatches = 0;
  int total_checks = 0;
  int cal_done_seen = 0;
  logic [15:0] w;

  gauge_status_readout gauge_status_readout_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
    .rst_pin_n_i(rst_pin_n_i), .gauge_moving_away_i(gauge_moving_away_i),
    .direction_vs_target_flag_i(direction_vs_target_flag_i), .off_target_i(off_target_i),
    .pointer_location_i(pointer_location_i), .ramp_step_raw_i(ramp_step_raw_i),
    .ramp_shortening_select_i(ramp_shortening_select_i),
    .device_status_word_i(device_status_word_i),
    .return_to_zero_active_i(return_to_zero_active_i), .bemf_valid_i(bemf_valid_i),
    .bemf_sample_i(bemf_sample_i), .gauge_on_flag_o(gauge_on_flag_o),
    .clock_cal_enable_o(clock_cal_enable_o), .clock_target_select_o(clock_target_select_o),
    .zero_return_step_time_o(zero_return_step_time_o),
    .zero_return_blanking_o(zero_return_blanking_o), .status_select_o(status_select_o),
    .cal_count_o(cal_count_o), .cal_done_o(cal_done_o), .zero_stop_o(zero_stop_o));

  spi_host_model spi_host_model_i (.mclk_i(mclk_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .si_o(si_i), .so_i(so_o));

  // 50 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // the done flag is a one-cycle pulse, so it is counted as it happens
  always @(posedge mclk_i) begin
    if (cal_done_o === 1'b1) cal_done_seen++;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // configuration and select command: enable bit 0, calibration bit 3, target bit 4
  function automatic logic [15:0] cfg_word(logic en, logic cal, logic tgt, logic [3:0] sel);
    return {CMD_CONFIG, 1'b0, sel, 3'b000, tgt, cal, 2'b00, en};
  endfunction : cfg_word

  // a select takes effect on the frame after the one that carries it
  task automatic sel_read(input logic en, input logic [3:0] sel, output logic [15:0] rx);
    logic [15:0] tmp;
    spi_host_model_i.xfer(cfg_word(en, 1'b0, 1'b0, sel), 16, tmp);
    spi_host_model_i.xfer(cfg_word(en, 1'b0, 1'b0, sel), 16, rx);
  endtask : sel_read

  task automatic bemf_pulse(input logic [14:0] s);
    @(posedge mclk_i);
    bemf_sample_i <= s;
    bemf_valid_i <= 1'b1;
    @(posedge mclk_i);
    bemf_valid_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : bemf_pulse

  // hang guard, well above the few thousand cycles the sequence needs
  initial begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    $display("[FAIL] watchdog expired");
    finish_test();
  end

  initial begin
    int widths[2];
    widths = '{250, 400};
    rst_n_i = 1'b0;
    rst_pin_n_i = 1'b1;
    {gauge_moving_away_i, direction_vs_target_flag_i, off_target_i} = 3'b000;
    pointer_location_i = 12'h000;
    ramp_step_raw_i = 8'h05;
    ramp_shortening_select_i = 2'h0;
    device_status_word_i = 16'h5AC3;
    return_to_zero_active_i = 1'b0;
    bemf_valid_i = 1'b0;
    bemf_sample_i = 15'h0000;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    check("cfg_after_reset", 16'h0000, {4'h0, gauge_on_flag_o, clock_cal_enable_o,
      clock_target_select_o, zero_return_step_time_o, zero_return_blanking_o, status_select_o});
    check("so_oe_n_idle", 16'h0001, {15'h0, so_oe_n_o});
    check("cal_count_reset", 16'd400, {4'h0, cal_count_o});
    // position word over every flag combination, enable toggling
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      {gauge_moving_away_i, direction_vs_target_flag_i, off_target_i} <= i[2:0];
      pointer_location_i <= {i[2:0], 9'h15A};
      sel_read(i[0], 4'hC, w);
      check("position_word", {i[0], i[2:0], i[2:0], 9'h15A}, w);
    end
    // location is the one present when select falls, not a later value
    pointer_location_i <= 12'h3C3;
    fork
      spi_host_model_i.xfer(cfg_word(1'b1, 1'b0, 1'b0, 4'hC), 16, w);
      begin
        repeat (30) @(posedge mclk_i);
        pointer_location_i <= 12'h0F0;
      end
    join
    check("position_at_cs_fall", 16'h3C3, {4'h0, w[11:0]});
    // velocity step, both encodings of the low select bit, every shortening choice
    for (int cut = 0; cut < 4; cut++) begin
      ramp_shortening_select_i <= cut[1:0];
      sel_read(1'b1, {3'b111, cut[0]}, w);
      check("velocity_step", {8'h00, 8'(5 + ((cut == 0) ? 0 : cut + 1))}, {8'h00, w[7:0]});
    end
    // unknown code and short frame leave select and enable alone
    spi_host_model_i.xfer(16'hFFFF, 16, w);
    spi_host_model_i.xfer(cfg_word(1'b0, 1'b0, 1'b0, 4'h8), 15, w);
    check("select_kept", 16'h001F, {11'h0, gauge_on_flag_o, status_select_o});
    // 1101 is not a velocity select, and 0xxx is the device word too
    sel_read(1'b1, 4'hD, w);
    check("device_word_sel_d", 16'h5AC3, w);
    sel_read(1'b1, 4'h3, w);
    check("device_word_sel_3", 16'h5AC3, w);
    // accumulate during a run, then hold after it
    @(posedge mclk_i);
    return_to_zero_active_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    bemf_pulse(15'h0003);
    bemf_pulse(15'h7FF8);
    sel_read(1'b1, 4'h8, w);
    check("acc_during_run", 16'hFFFB, w);
    check("zero_stop_neg", 16'h0001, {15'h0, zero_stop_o});
    @(posedge mclk_i);
    return_to_zero_active_i <= 1'b0;
    bemf_pulse(15'h0001);
    sel_read(1'b1, 4'hB, w);
    check("acc_held", 16'h7FFB, w);
    check("zero_stop_idle", 16'h0000, {15'h0, zero_stop_o});
    // reset pin held low clears the integral and the select
    @(posedge mclk_i);
    rst_pin_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rst_pin_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    check("select_after_pin", 16'h0000, {12'h0, status_select_o});
    sel_read(1'b1, 4'h8, w);
    check("acc_after_pin", 16'h0000, w);
    // zero return timing fields
    spi_host_model_i.xfer({CMD_ZERO_CONFIG, 8'h00, 1'b1, 4'hA}, 16, w);
    check("zero_cfg_a", 16'h001A, {11'h0, zero_return_blanking_o, zero_return_step_time_o});
    spi_host_model_i.xfer({CMD_ZERO_CONFIG, 8'h00, 1'b0, 4'h5}, 16, w);
    check("zero_cfg_b", 16'h0005, {11'h0, zero_return_blanking_o, zero_return_step_time_o});
    // calibration: arm, then one measured select pulse
    foreach (widths[k]) begin
      spi_host_model_i.xfer(cfg_word(1'b1, 1'b1, 1'b1, 4'hC), 16, w);
      check("cal_armed", 16'h0003, {14'h0, clock_cal_enable_o, clock_target_select_o});
      cal_done_seen = 0;
      spi_host_model_i.cal_pulse(widths[k]);
      check("cal_done_pulses", 16'h0001, 16'(cal_done_seen));
      total_checks++;
      // an unknown count must not slip through the range test
      if ($isunknown(cal_count_o) || cal_count_o + 1 < widths[k] || cal_count_o > widths[k] + 1) begin
        mismatches++;
        $display("[FAIL] cal_count expected %0d seen %0d", widths[k], cal_count_o);
      end
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
